//--- inc/sadc_defs.vh
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH
// ==========================================================
// register offsets
`define SADC_OFS_CTRL     8'hd2
`define SADC_OFS_RES_HI   8'hd3
`define SADC_OFS_RES_LO   8'hd4
`define SADC_OFS_REF      8'hd5
`define SADC_OFS_PIN4     8'hd6
`define SADC_OFS_PIN5     8'hd7
`define SADC_OFS_IRQ_FLAG 8'hd8
`define SADC_OFS_IRQ_EN   8'hd9
// ==========================================================
// field positions
`define SADC_CTRL_EN      7
`define SADC_CTRL_START   6
`define SADC_CTRL_EOC     5
`define SADC_LO_CHANNEL_GLOBAL_ENABLE      6
`define SADC_LO_CKS_HI    5
`define SADC_LO_CKS_LO    4
`define SADC_REF_EXTH     7
`define SADC_REF_EXTL     6
`define SADC_REF_PWM      4
`define SADC_REF_VDD      2
`define SADC_REF_LVL_HI   1
`define SADC_REF_LVL_LO   0
// ==========================================================
// channel codes
`define SADC_CH_EXT_LAST  5'h0b
`define SADC_CH_AMP0      5'h18
`define SADC_CH_AMP1      5'h19
`define SADC_CH_LEVEL     5'h1a
// ==========================================================
// clock divider codes and conversion timing
`define SADC_CKS_DIV16    2'h0
`define SADC_CKS_DIV8     2'h1
`define SADC_CKS_DIV1     2'h2
`define SADC_CKS_DIV2     2'h3
`define SADC_DIV16_LAST   4'hf
`define SADC_DIV8_LAST    4'h7
`define SADC_DIV2_LAST    4'h1
`define SADC_DIV1_LAST    4'h0
`define SADC_CONV_LAST    6'h3f
`define SADC_SAMPLE_SLOTS 4'h4
`define SADC_SLOT_LAST    4'hf
`define SADC_DECIDE_PHASE 2'h3
`define SADC_RES_BITS     12
`define SADC_RES_ZERO     12'h000
`define SADC_BYTE_ZERO    8'h00
`endif

//--- src/sadc_control.v
`timescale 1ns/1ps
`include "sadc_defs.vh"

module sadc_control
(
  input  wire        clk_in,          // system oscillator
  input  wire        rst_n_in,        // async reset, active low
  input  wire [7:0]  addr_in,         // register address
  input  wire [7:0]  wdata_in,        // register write data
  input  wire        wr_in,           // write strobe
  input  wire        rd_in,           // read strobe
  output reg  [7:0]  rdata_out,       // read data, cycle after rd_in
  input  wire        pwm_enable_in,   // pwm generator enable level
  input  wire        irq_ack_in,      // interrupt taken pulse
  output wire        irq_req_out,     // converter interrupt request
  input  wire        comp_in,         // 1: input at or above trial level
  output reg  [11:0] dac_code_out,    // trial code to the sar dac
  output reg         sample_out,      // sampling phase active
  output reg         busy_out,        // conversion running
  output reg  [4:0]  channel_out,     // channel code to the mux
  output reg  [11:0] ext_sel_out,     // one-hot external input switch
  output reg         amp0_sel_out,    // amplifier 0 output switch
  output reg         amp1_sel_out,    // amplifier 1 output switch
  output reg         level_sel_out,   // internal level switch
  output reg         high_ref_ext_out, // high ref from external pin
  output reg  [1:0]  high_ref_lvl_out, // internal high ref level
  output reg         high_ref_vdd_out, // force internal high ref to supply
  output reg         low_ref_ext_out, // low ref from external pin
  output reg  [7:0]  pin4_dig_en_out, // port 4 digital input enables
  output reg  [5:0]  pin5_dig_en_out  // port 5 digital input enables
);

  // ==========================================================
  // reset release
  reg        rst_s1_q;
  reg        rst_s2_q;
  // only the second stage feeds the logic; the first may still be settling
  wire       rst_n = rst_s2_q;

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // functions
  // converter clock divider
  function [3:0] div_last;
    input [1:0] cks;
    begin
      case (cks)
        `SADC_CKS_DIV16: div_last = `SADC_DIV16_LAST;
        `SADC_CKS_DIV8:  div_last = `SADC_DIV8_LAST;
        `SADC_CKS_DIV1:  div_last = `SADC_DIV1_LAST;
        default:         div_last = `SADC_DIV2_LAST;
      endcase
    end
  endfunction

  function is_write;
    input [7:0] a;
    begin
      is_write = wr_in && (addr_in == a);
    end
  endfunction

  // ==========================================================
  // software registers
  reg        enable_q;
  reg        eoc_q;
  reg [4:0]  chan_q;
  reg        channel_global_enable_q;
  reg [1:0]  cks_q;
  reg        exth_q;
  reg        extl_q;
  reg        pwm_trig_q;
  reg        vdd_q;
  reg [1:0]  lvl_q;
  reg [7:0]  pin4_q;
  reg [5:0]  pin5_q;
  reg        irq_flag_q;
  reg        irq_en_q;
  reg [11:0] result_q;

  // ==========================================================
  // conversion state
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [1:0]  state_q;
  reg [3:0]  div_q;
  reg [5:0]  step_q;
  reg [11:0] acc_q;
  reg [11:0] acc_d;
  reg [3:0]  bit_idx;

  // tick closes one period of the divided converter clock
  wire tick      = (div_q == div_last(cks_q));
  // four ticks per slot; slots 0-3 sample, slots 4-15 settle one bit each, msb first
  // the trial code is registered, so comp_in is only trusted on the slot's last tick
  wire decide    = tick && (step_q[1:0] == `SADC_DECIDE_PHASE)
                   && (step_q[5:2] >= `SADC_SAMPLE_SLOTS);
  wire last_step = tick && (step_q == `SADC_CONV_LAST);
  wire sw_start  = is_write(`SADC_OFS_CTRL) && wdata_in[`SADC_CTRL_EN]
                   && wdata_in[`SADC_CTRL_START];
  // pwm gating
  // pwm starts follow the level, so a held enable restarts right after completion
  wire pwm_start = pwm_trig_q && pwm_enable_in && enable_q;
  // a disabling write aborts at the very edge on which it lands
  wire en_next   = is_write(`SADC_OFS_CTRL) ? wdata_in[`SADC_CTRL_EN] : enable_q;
  wire done      = (state_q == ST_CONV) && last_step && en_next;

  always @*
  begin
    bit_idx = `SADC_SLOT_LAST - step_q[5:2];
    acc_d   = acc_q;
    if (decide)
      acc_d[bit_idx] = comp_in;
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= ST_IDLE;
      div_q    <= 4'h0;
      step_q   <= 6'h00;
      acc_q    <= `SADC_RES_ZERO;
      // software must still treat the result as undefined until a first completion
      result_q <= `SADC_RES_ZERO;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          div_q  <= 4'h0;
          step_q <= 6'h00;
          acc_q  <= `SADC_RES_ZERO;
          if (en_next && (sw_start || pwm_start))
            state_q <= ST_CONV;
        end
        ST_CONV:
        begin
          div_q <= tick ? 4'h0 : div_q + 4'h1;
          acc_q <= acc_d;
          if (tick)
            step_q <= step_q + 6'h01;
          if (!en_next)
            state_q <= ST_IDLE;
          else if (last_step)
          begin
            state_q  <= ST_IDLE;
            result_q <= acc_d;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // register writes and flags
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q   <= 1'b0;
      eoc_q      <= 1'b0;
      chan_q     <= 5'h00;
      channel_global_enable_q     <= 1'b0;
      cks_q      <= `SADC_CKS_DIV16;
      exth_q     <= 1'b0;
      extl_q     <= 1'b0;
      pwm_trig_q <= 1'b0;
      vdd_q      <= 1'b0;
      lvl_q      <= 2'h0;
      pin4_q     <= `SADC_BYTE_ZERO;
      pin5_q     <= 6'h00;
      irq_flag_q <= 1'b0;
      irq_en_q   <= 1'b0;
    end
    else
    begin
      enable_q <= en_next;
      if (is_write(`SADC_OFS_CTRL))
        chan_q <= wdata_in[4:0];
      if (done)
        eoc_q <= 1'b1;
      else if (is_write(`SADC_OFS_CTRL))
        eoc_q <= wdata_in[`SADC_CTRL_EOC];
      if (is_write(`SADC_OFS_RES_LO))
      begin
        channel_global_enable_q <= wdata_in[`SADC_LO_CHANNEL_GLOBAL_ENABLE];
        cks_q  <= wdata_in[`SADC_LO_CKS_HI:`SADC_LO_CKS_LO];
      end
      if (is_write(`SADC_OFS_REF))
      begin
        exth_q     <= wdata_in[`SADC_REF_EXTH];
        extl_q     <= wdata_in[`SADC_REF_EXTL];
        pwm_trig_q <= wdata_in[`SADC_REF_PWM];
        vdd_q      <= wdata_in[`SADC_REF_VDD];
        lvl_q      <= wdata_in[`SADC_REF_LVL_HI:`SADC_REF_LVL_LO];
      end
      if (is_write(`SADC_OFS_PIN4))
        pin4_q <= wdata_in;
      if (is_write(`SADC_OFS_PIN5))
        pin5_q <= wdata_in[5:0];
      if (is_write(`SADC_OFS_IRQ_EN))
        irq_en_q <= wdata_in[0];
      if (done)
        irq_flag_q <= 1'b1;
      else if (irq_ack_in)
        irq_flag_q <= 1'b0;
      else if (is_write(`SADC_OFS_IRQ_FLAG))
        irq_flag_q <= wdata_in[0];
    end
  end

  assign irq_req_out = irq_flag_q && irq_en_q;

  // ==========================================================
  // read port
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_out <= `SADC_BYTE_ZERO;
    else if (rd_in)
    begin
      case (addr_in)
        `SADC_OFS_CTRL:
          rdata_out <= {enable_q, (state_q == ST_CONV), eoc_q, chan_q};
        `SADC_OFS_RES_HI:
          rdata_out <= result_q[11:4];
        `SADC_OFS_RES_LO:
          rdata_out <= {1'b0, channel_global_enable_q, cks_q, result_q[3:0]};
        `SADC_OFS_REF:
          rdata_out <= {exth_q, extl_q, 1'b0, pwm_trig_q, 1'b0, vdd_q, lvl_q};
        `SADC_OFS_PIN4:
          rdata_out <= pin4_q;
        `SADC_OFS_PIN5:
          rdata_out <= {2'h0, pin5_q};
        `SADC_OFS_IRQ_FLAG:
          rdata_out <= {7'h00, irq_flag_q};
        `SADC_OFS_IRQ_EN:
          rdata_out <= {7'h00, irq_en_q};
        default:
          rdata_out <= `SADC_BYTE_ZERO;
      endcase
    end
    // idle read data falls back to zero so a stale byte never looks like an answer
    else
      rdata_out <= `SADC_BYTE_ZERO;
  end

  // ==========================================================
  // channel decode
  // a switch closes only while the global channel enable is set
  function chan_on;
    input [4:0] code;
    begin
      chan_on = channel_global_enable_q && (chan_q == code);
    end
  endfunction

  // ==========================================================
  // analog side controls, registered
  wire [11:0] ext_sel_d;
  genvar g;
  generate
    for (g = 0; g < `SADC_RES_BITS; g = g + 1)
    begin : g_ext
      assign ext_sel_d[g] = channel_global_enable_q && ({27'h0000000, chan_q} == g);
    end
  endgenerate

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_code_out     <= `SADC_RES_ZERO;
      sample_out       <= 1'b0;
      busy_out         <= 1'b0;
      channel_out      <= 5'h00;
      ext_sel_out      <= `SADC_RES_ZERO;
      amp0_sel_out     <= 1'b0;
      amp1_sel_out     <= 1'b0;
      level_sel_out    <= 1'b0;
      high_ref_ext_out <= 1'b0;
      high_ref_lvl_out <= 2'h0;
      high_ref_vdd_out <= 1'b0;
      low_ref_ext_out  <= 1'b0;
      pin4_dig_en_out  <= `SADC_BYTE_ZERO;
      pin5_dig_en_out  <= 6'h00;
    end
    else
    begin
      busy_out   <= (state_q == ST_CONV);
      sample_out <= (state_q == ST_CONV) && (step_q[5:2] < `SADC_SAMPLE_SLOTS);
      dac_code_out <= (step_q[5:2] >= `SADC_SAMPLE_SLOTS) && (state_q == ST_CONV)
                      ? (acc_d | (12'h001 << bit_idx)) : `SADC_RES_ZERO;
      channel_out   <= chan_q;
      ext_sel_out   <= ext_sel_d;
      amp0_sel_out  <= chan_on(`SADC_CH_AMP0);
      amp1_sel_out  <= chan_on(`SADC_CH_AMP1);
      level_sel_out <= chan_on(`SADC_CH_LEVEL);
      high_ref_ext_out <= exth_q;
      high_ref_lvl_out <= lvl_q;
      high_ref_vdd_out <= vdd_q;
      low_ref_ext_out  <= extl_q;
      pin4_dig_en_out  <= ~pin4_q;
      pin5_dig_en_out  <= ~pin5_q;
    end
  end

endmodule // sadc_control

//--- sim/sadc_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checks for the converter control block
module sadc_monitor
(
  input logic        clk_in,           // clock
  input logic        rst_n_in,         // reset, active low
  input logic [7:0]  addr_in,          // address
  input logic [7:0]  wdata_in,         // write data
  input logic        wr_in,            // write strobe
  input logic        rd_in,            // read strobe
  input logic [7:0]  rdata_out,        // read data
  input logic [4:0]  channel_out,      // channel code
  input logic [11:0] ext_sel_out,      // external switches
  input logic        amp0_sel_out,     // amplifier 0 switch
  input logic        amp1_sel_out,     // amplifier 1 switch
  input logic        level_sel_out,    // internal level switch
  input logic        high_ref_ext_out, // external high ref
  input logic [1:0]  high_ref_lvl_out, // internal level
  input logic        high_ref_vdd_out, // supply high ref
  input logic        low_ref_ext_out,  // external low ref
  input logic [7:0]  pin4_dig_en_out   // port 4 digital enables
);
  logic [7:0] wd1_q;
  logic [7:0] wd2_q;

  // write data delayed to line up with two-stage outputs
  always_ff @(posedge clk_in)
  begin
    wd1_q <= wdata_in;
    wd2_q <= wd1_q;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence wr_at(a);
    wr_in && addr_in == a;
  endsequence

  sel_onehot_a:
    assert property ($onehot0({ext_sel_out, amp0_sel_out, amp1_sel_out, level_sel_out}))
    else $error("several channel switches closed");
  ext_match_a:
    assert property (|ext_sel_out |-> ext_sel_out == 12'h001 << channel_out)
    else $error("external switch differs from channel code");
  amp_code_a:
    assert property (amp0_sel_out |-> channel_out == 5'h18)
    else $error("amplifier switch with wrong code");
  level_code_a:
    assert property (level_sel_out |-> channel_out == 5'h1a)
    else $error("level switch with wrong code");
  channel_global_enable_off_a:
    assert property (wr_at(8'hd4) ##0 !wdata_in[6] |-> ##2
      {ext_sel_out, amp0_sel_out, amp1_sel_out, level_sel_out} == 15'h0000)
    else $error("channel connected with global enable off");
  ref_copy_a:
    assert property (wr_at(8'hd5) |-> ##2 {high_ref_ext_out, low_ref_ext_out,
      high_ref_vdd_out, high_ref_lvl_out} == {wd2_q[7:6], wd2_q[2:0]})
    else $error("reference selects differ from register");
  pin_iso_a:
    assert property (wr_at(8'hd6) |-> ##2 pin4_dig_en_out == ~wd2_q)
    else $error("digital input not isolated");
  rdata_idle_a:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without read");
endmodule // sadc_monitor

bind sadc_control sadc_monitor u_mon (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .channel_out, .ext_sel_out, .amp0_sel_out, .amp1_sel_out,
  .level_sel_out, .high_ref_ext_out, .high_ref_lvl_out, .high_ref_vdd_out,
  .low_ref_ext_out, .pin4_dig_en_out);

//--- sim/sadc_analog_model.sv
`timescale 1ns/1ps
// ==========================================================
// analog side: fixed level per channel and ideal comparator
module sadc_analog_model
(
  input  logic [11:0] dac_code_in,  // trial code
  input  logic [11:0] ext_sel_in,   // external switches
  input  logic        amp0_sel_in,  // amplifier 0 switch
  input  logic        amp1_sel_in,  // amplifier 1 switch
  input  logic        level_sel_in, // internal level switch
  output logic        comp_out      // input at or above trial
);
  logic [11:0] lvl;

  always_comb
  begin
    lvl = 12'h000;
    for (int i = 0; i < 12; i++)
      if (ext_sel_in[i])
        lvl = {i[3:0], 8'h3c};
    if (amp0_sel_in)
      lvl = 12'hfff;
    if (level_sel_in)
      lvl = 12'h800;
  end

  assign comp_out = lvl >= dac_code_in;
endmodule // sadc_analog_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        pwm_enable_in = 1'b0;
  logic        irq_ack_in = 1'b0;
  wire  [7:0]  rdata_out;
  wire         irq_req_out, comp_in, sample_out, busy_out;
  wire  [11:0] dac_code_out, ext_sel_out;
  wire  [4:0]  channel_out;
  wire         amp0_sel_out, amp1_sel_out, level_sel_out;
  wire         high_ref_ext_out, high_ref_vdd_out, low_ref_ext_out;
  wire  [1:0]  high_ref_lvl_out;
  wire  [7:0]  pin4_dig_en_out;
  wire  [5:0]  pin5_dig_en_out;
  int          fails = 0;
  int          n_tests = 0;
  int          n, m, ns;
  logic [4:0]  rc [8] = '{5'h00, 5'h05, 5'h0b, 5'h0c, 5'h18, 5'h19, 5'h1a, 5'h1f};
  logic [1:0]  rk [8] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3, 2'h2, 2'h2};
  logic [11:0] rr [8] = '{12'h03c, 12'h53c, 12'hb3c, 12'h000, 12'hfff, 12'h000, 12'h800,
                          12'h000};

  sadc_control u_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .pwm_enable_in, .irq_ack_in, .irq_req_out, .comp_in, .dac_code_out, .sample_out,
    .busy_out, .channel_out, .ext_sel_out, .amp0_sel_out, .amp1_sel_out, .level_sel_out,
    .high_ref_ext_out, .high_ref_lvl_out, .high_ref_vdd_out, .low_ref_ext_out,
    .pin4_dig_en_out, .pin5_dig_en_out);

  sadc_analog_model u_ana (.dac_code_in(dac_code_out), .ext_sel_in(ext_sel_out),
    .amp0_sel_in(amp0_sel_out), .amp1_sel_in(amp1_sel_out), .level_sel_in(level_sel_out),
    .comp_out(comp_in));

  always #5 clk_in = ~clk_in;

  // ==========================================================
  // bus and check tasks
  task automatic chk(input string nm, input logic [11:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e, input string nm);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(nm, {4'h0, e}, {4'h0, rdata_out});
  endtask

  function automatic int dv(logic [1:0] k);
    return k == 2'h0 ? 16 : k == 2'h1 ? 8 : k == 2'h2 ? 1 : 2;
  endfunction

  // mode 1 repeats the start mid-run, mode 2 clears the enable mid-run
  task automatic run(input logic [4:0] c, input logic [1:0] k, input int md, output int t);
    wr(8'hd4, {2'b01, k, 4'h0});
    wr(8'hd2, {3'b100, c});
    wr(8'hd2, {3'b110, c});
    t = 0;
    ns = 0;
    while (t < 2000)
    begin
      @(posedge clk_in);
      t++;
      if (md != 0 && t == 10)
      begin
        wdata_in <= (md == 2) ? 8'h00 : {3'b110, c};
        wr_in <= 1'b1;
      end
      if (t == 11)
        wr_in <= 1'b0;
      #1;
      ns += sample_out;
      if (t > 2 && busy_out !== 1'b1)
        break;
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    fails++;
    summarize;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    wr(8'hd5, 8'h04);
    for (int i = 0; i < 8; i++)
    begin
      run(rc[i], rk[i], 0, n);
      chk("conv time", 12'(64 * dv(rk[i]) + 1), n[11:0]);
      chk("sample time", 12'(16 * dv(rk[i])), ns[11:0]);
      rd(8'hd3, rr[i][11:4], "result high");
      rd(8'hd4, {2'b01, rk[i], rr[i][3:0]}, "result low");
      rd(8'hd2, {3'b101, rc[i]}, "ctrl");
      rd(8'hd8, 8'h01, "irq flag");
      wr(8'hd8, 8'h00);
    end
    $display("table rows done");
    run(5'h05, 2'h2, 1, n);
    chk("restart time", 12'd65, n[11:0]);
    rd(8'hd3, 8'h53, "restart result");
    wr(8'hd8, 8'h00);
    run(5'h18, 2'h2, 2, n);
    rd(8'hd2, 8'h00, "abort ctrl");
    rd(8'hd8, 8'h00, "abort flag");
    rd(8'hd3, 8'h53, "abort result");
    $display("restart and abort done");
    wr(8'hd9, 8'h01);
    run(5'h00, 2'h2, 0, n);
    chk("irq raised", 12'h001, {11'h0, irq_req_out});
    @(posedge clk_in);
    irq_ack_in <= 1'b1;
    @(posedge clk_in);
    irq_ack_in <= 1'b0;
    #1 chk("irq taken", 12'h000, {11'h0, irq_req_out});
    @(posedge clk_in);
    pwm_enable_in <= 1'b1;
    wr(8'hd2, 8'h80);
    repeat (20) @(posedge clk_in);
    #1 chk("pwm gated", 12'h000, {11'h0, busy_out});
    wr(8'hd5, 8'h10);
    m = 0;
    repeat (300) @(posedge clk_in) #1 m += busy_out;
    chk("pwm continuous", 12'h001, {11'h0, m > 280});
    @(posedge clk_in);
    pwm_enable_in <= 1'b0;
    repeat (80) @(posedge clk_in);
    #1 chk("pwm stopped", 12'h000, {11'h0, busy_out});
    $display("irq and pwm done");
    rd(8'h00, 8'h00, "unmapped");
    wr(8'hd3, 8'hff);
    rd(8'hd3, 8'h03, "read only result");
    wr(8'hd6, 8'h20);
    wr(8'hd5, 8'hc6);
    wr(8'hd4, 8'h20);
    repeat (2) @(posedge clk_in);
    #1 chk("pin4 digital", 12'h0df, {4'h0, pin4_dig_en_out});
    chk("refs", 12'h01e, {7'h0, high_ref_ext_out, low_ref_ext_out, high_ref_vdd_out,
        high_ref_lvl_out});
    chk("channel_global_enable off", 12'h000, ext_sel_out);
    wr(8'hd6, 8'h00);
    wr(8'hd7, 8'h08);
    repeat (2) @(posedge clk_in);
    #1 chk("pin5 digital", 12'h037, {6'h0, pin5_dig_en_out});
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk("reset pins", 12'h0ff, {4'h0, pin4_dig_en_out});
    rd(8'hd2, 8'h00, "reset ctrl");
    rd(8'hd5, 8'h00, "reset refs");
    $display("config and reset done");
    summarize;
  end
endmodule // tb_top
